//--- rtl/cansr_defines.svh
// register offsets, field positions, reset values and counts for the can status block
// assumes word addressing on the avalon slave, one byte register per word
`ifndef CANSR_DEFINES_SVH
`define CANSR_DEFINES_SVH

`define CANSR_ADDR_W          4
`define CANSR_OFF_MASTER_CTRL 4'h0
`define CANSR_OFF_MASTER_STAT 4'h1
`define CANSR_OFF_TX_STATUS   4'h2
`define CANSR_OFF_TX_PRIO     4'h3
`define CANSR_OFF_RX_QUEUE    4'h4
`define CANSR_OFF_INT_EN      4'h5
`define CANSR_OFF_ERR_STATUS  4'h6
`define CANSR_OFF_ERR_INT_EN  4'h7

`define CANSR_RST_MASTER_CTRL 8'h02
`define CANSR_RST_TX_PRIO     8'h0c
`define CANSR_RST_ZERO        8'h00

// master control / status
`define CANSR_B_INIT_REQ      0
`define CANSR_B_SLEEP_REQ     1
`define CANSR_B_INIT_ACK      0
`define CANSR_B_SLEEP_ACK     1
`define CANSR_B_ERR_SUM       2
`define CANSR_B_WAKEUP        3
// transmit status
`define CANSR_B_MBOX0_REQUEST_DONE         0
`define CANSR_B_MBOX1_REQUEST_DONE         1
`define CANSR_B_MBOX0_TX_SUCCESS         4
`define CANSR_B_MBOX1_TX_SUCCESS         5
// receive queue
`define CANSR_B_RELEASE       5
`define CANSR_B_OVERRUN       4
`define CANSR_B_FULL          3
// interrupt enable
`define CANSR_B_MAILBOX_EMPTY_INT_EN         0
`define CANSR_B_PENDING_INT_EN         1
`define CANSR_B_QUEUE_FULL_INT_EN          2
`define CANSR_B_OVERRUN_INT_EN         3
`define CANSR_B_WAKEUP_INT_EN         7
// error status / enable
`define CANSR_B_EWG           0
`define CANSR_B_EPV           1
`define CANSR_B_BUS_OFF_FLAG          2
`define CANSR_B_LEC_LO        4
`define CANSR_B_LAST_ERROR_INT_EN         4
`define CANSR_B_ERROR_INT_EN         7

`define CANSR_INT_EN_MASK     8'h8f
`define CANSR_ERR_EN_MASK     8'h97
`define CANSR_CTRL_MASK       8'h03

`define CANSR_QUEUE_DEPTH     2'h3
`define CANSR_SYNC_BITS       4'hb
`define CANSR_LIMIT_WARN      9'h060
`define CANSR_LIMIT_PASSIVE   9'h07f
`define CANSR_LEC_SW_ONLY     3'h7

`endif

//--- rtl/cansr_pkg.sv
// types shared by the can status block
// assumes cansr_defines.svh supplies all numeric constants
package cansr_pkg;

  typedef enum logic [1:0] {
    CANSR_NORMAL = 2'b00,
    CANSR_INIT   = 2'b01,
    CANSR_SYNC   = 2'b10,
    CANSR_SLEEP  = 2'b11
  } cansr_mode_t;

  typedef enum logic [2:0] {
    CANSR_LEC_NONE  = 3'b000,
    CANSR_LEC_STUFF = 3'b001,
    CANSR_LEC_FORM  = 3'b010,
    CANSR_LEC_ACK   = 3'b011,
    CANSR_LEC_BIT1  = 3'b100,
    CANSR_LEC_BIT0  = 3'b101,
    CANSR_LEC_CRC   = 3'b110,
    CANSR_LEC_SW    = 3'b111
  } cansr_lec_t;

endpackage

//--- rtl/cansr_status.sv
// status, priority, receive queue, interrupt enable and error status of a can controller
// assumes protocol core events on i_mclk as one-cycle pulses, rx pin asynchronous
//
// Behaviour
// - sleep ack rises once sleep is entered, falls when sleep request clears.
// - init ack rises once init mode is entered after init request.
// - after init ends, init ack clears only after 11 recessive bits.
// - per-mailbox success flag set on good completion, cleared on re-request or done-clear.
// - request-done flag set on finish; software clears by writing one.
// - both pending: lower-ranked mailbox shows lowest flag; otherwise both zero.
// - empty flag high while mailbox has no request; priority resets with both set.
// - mailbox code gives next free mailbox, else the lowest-priority one.
// - release bit frees output slot if not empty, then hardware clears it.
// - overrun set when filtered message arrives with queue full; write one clears.
// - full set at three messages; cleared by write one or by release.
// - pending count rises per stored message, falls per release.
// - wakeup, overrun, full flags raise interrupts when enabled.
// - pending interrupt only on count moving from zero to one.
// - mailbox empty interrupt whenever a request-done flag becomes set.
// - last error field holds latest error, cleared by error-free frame.
// - error codes 0..6 by hardware; 7 only written by software.
// - bus-off flag set when transmit error count passes 255.
// - error passive flag when either count exceeds 127.
// - error warning flag when either count exceeds 96.
// - master error enable gives interrupt while enabled error is pending.
// - last-error enable sets summary flag when hardware writes error code.
// - summary flag set by enabled error status bit; software clears it.
// - bus-off, passive, warning enables let their flags set the summary flag.
//
// Our own choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ps
`include "cansr_defines.svh"

module cansr_status
  import cansr_pkg::*;
(
  input  wire logic                    i_mclk,
  input  wire logic                    i_rst_n,
  input  wire logic [`CANSR_ADDR_W-1:0] i_avs_address,
  input  wire logic                    i_avs_read,
  input  wire logic                    i_avs_write,
  input  wire logic [31:0]             i_avs_writedata,
  input  wire logic [3:0]              i_avs_byteenable,
  output logic      [31:0]             o_avs_readdata,
  output logic                         o_avs_waitrequest,
  input  wire logic                    i_can_rx,
  input  wire logic                    i_bit_tick,
  input  wire logic                    i_bus_idle,
  input  wire logic                    i_sof_detect,
  input  wire logic [1:0]              i_tx_request,
  input  wire logic [1:0]              i_tx_done,
  input  wire logic [1:0]              i_tx_ok,
  input  wire logic                    i_mbox0_first,
  input  wire logic                    i_rx_store,
  input  wire logic                    i_error_detect,
  input  wire logic [2:0]              i_error_code,
  input  wire logic                    i_frame_ok,
  input  wire logic [8:0]              i_tx_err_count,
  input  wire logic [7:0]              i_rx_err_count,
  output logic                         o_init_mode,
  output logic                         o_sleep_mode,
  output logic                         o_rx_release,
  output logic                         o_tx_irq,
  output logic                         o_rx_irq,
  output logic                         o_status_irq
);

  // bus slave: one wait cycle, access takes effect on the second cycle
  logic       done_r;
  logic       req;
  logic       wr_acc;
  logic [7:0] wdat;

  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~done_r;
  assign wr_acc            = i_avs_write & done_r & i_avs_byteenable[0];
  assign wdat              = i_avs_writedata[7:0];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      done_r <= 1'b0;
    end else begin
      done_r <= req & ~done_r;
    end
  end

  function automatic logic wr_hit(input logic [`CANSR_ADDR_W-1:0] off);
    wr_hit = wr_acc && (i_avs_address == off);
  endfunction

  // rx pin synchroniser; level changes once stages two and three agree
  logic [2:0] rx_sync_r;
  logic       rx_q_r;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_sync_r <= 3'h7;
      rx_q_r    <= 1'b1;
    end else begin
      rx_sync_r <= {rx_sync_r[1:0], i_can_rx};
      if (rx_sync_r[1] == rx_sync_r[2]) begin
        rx_q_r <= rx_sync_r[2];
      end
    end
  end

  // master control (request bits) and operating mode
  logic [7:0]  ctrl_r;
  cansr_mode_t mode_r;
  logic [3:0]  recessive_r;
  logic        init_req;
  logic        sleep_req;

  assign init_req  = ctrl_r[`CANSR_B_INIT_REQ];
  assign sleep_req = ctrl_r[`CANSR_B_SLEEP_REQ];

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ctrl_r <= `CANSR_RST_MASTER_CTRL;
    end else if (wr_hit(`CANSR_OFF_MASTER_CTRL)) begin
      ctrl_r <= wdat & `CANSR_CTRL_MASK;
    end
  end

  // entering init or sleep from normal waits for the current frame to finish
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      mode_r <= CANSR_NORMAL;
    end else begin
      unique case (mode_r)
        CANSR_NORMAL: begin
          if (init_req && i_bus_idle) begin
            mode_r <= CANSR_INIT;
          end else if (sleep_req && i_bus_idle) begin
            mode_r <= CANSR_SLEEP;
          end
        end
        CANSR_INIT: begin
          if (!init_req) begin
            mode_r <= CANSR_SYNC;
          end
        end
        CANSR_SYNC: begin
          if (init_req) begin
            mode_r <= CANSR_INIT;
          end else if (recessive_r == `CANSR_SYNC_BITS) begin
            mode_r <= CANSR_NORMAL;
          end
        end
        CANSR_SLEEP: begin
          if (init_req) begin
            mode_r <= CANSR_INIT;
          end else if (!sleep_req) begin
            mode_r <= CANSR_NORMAL;
          end
        end
      endcase
    end
  end

  // consecutive recessive bits seen while resynchronising
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      recessive_r <= 4'h0;
    end else if (mode_r != CANSR_SYNC) begin
      recessive_r <= 4'h0;
    end else if (i_bit_tick && recessive_r != `CANSR_SYNC_BITS) begin
      recessive_r <= rx_q_r ? recessive_r + 4'h1 : 4'h0;
    end
  end

  logic init_ack;
  logic sleep_ack;
  assign init_ack     = (mode_r == CANSR_INIT) || (mode_r == CANSR_SYNC);
  assign sleep_ack    = (mode_r == CANSR_SLEEP);
  assign o_init_mode  = init_ack;
  assign o_sleep_mode = sleep_ack;

  // wakeup flag: set wins over write-one clear
  logic wakeup_flag_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      wakeup_flag_r <= 1'b0;
    end else if (sleep_ack && i_sof_detect) begin
      wakeup_flag_r <= 1'b1;
    end else if (wr_hit(`CANSR_OFF_MASTER_STAT) && wdat[`CANSR_B_WAKEUP]) begin
      wakeup_flag_r <= 1'b0;
    end
  end

  // transmit mailboxes
  logic [1:0] pending_r;
  logic [1:0] request_done_r;
  logic [1:0] tx_success_r;
  logic [1:0] rqcp_clr;

  assign rqcp_clr = (wr_acc && i_avs_address == `CANSR_OFF_TX_STATUS) ?
                    {wdat[`CANSR_B_MBOX1_REQUEST_DONE], wdat[`CANSR_B_MBOX0_REQUEST_DONE]} : 2'h0;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      pending_r <= 2'h0;
    end else begin
      pending_r <= (pending_r | i_tx_request) & ~i_tx_done;
    end
  end

  // done wins over a same-cycle clear so no completion is lost
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      request_done_r <= 2'h0;
    end else begin
      request_done_r <= i_tx_done | (request_done_r & ~rqcp_clr & ~i_tx_request);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      tx_success_r <= 2'h0;
    end else begin
      tx_success_r <= (i_tx_done & i_tx_ok) |
                      (tx_success_r & ~rqcp_clr & ~i_tx_request);
    end
  end

  logic [1:0] mbox_empty;
  logic       both_pending;
  logic       mbox0_lowest_prio;
  logic       mbox1_lowest_prio;
  logic [1:0] mbox_code;

  assign mbox_empty        = ~pending_r;
  assign both_pending      = &pending_r;
  assign mbox0_lowest_prio = both_pending & ~i_mbox0_first;
  assign mbox1_lowest_prio = both_pending & i_mbox0_first;

  always_comb begin
    if (mbox_empty[0]) begin
      mbox_code = 2'h0;
    end else if (mbox_empty[1]) begin
      mbox_code = 2'h1;
    end else begin
      mbox_code = {1'b0, mbox1_lowest_prio};
    end
  end

  // receive queue bookkeeping; storage itself lives in the mailbox ram
  logic [1:0] rx_pending_count_r;
  logic       rx_release_output_r;
  logic       rx_overrun_r;
  logic       rx_full_r;
  logic       q_full;
  logic       q_store;
  logic       q_release;
  logic       rxq_wr;

  assign q_full       = (rx_pending_count_r == `CANSR_QUEUE_DEPTH);
  assign q_store      = i_rx_store & ~q_full;
  assign q_release    = rx_release_output_r;
  assign o_rx_release = q_release;
  // decoded inline: a function in a continuous assign would miss its non-argument inputs
  assign rxq_wr       = wr_acc && (i_avs_address == `CANSR_OFF_RX_QUEUE);

  // release only latches when a message is present
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_release_output_r <= 1'b0;
    end else if (rx_release_output_r) begin
      rx_release_output_r <= 1'b0;
    end else if (rxq_wr && wdat[`CANSR_B_RELEASE] && rx_pending_count_r != 2'h0) begin
      rx_release_output_r <= 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_pending_count_r <= 2'h0;
    end else if (q_store && !q_release) begin
      rx_pending_count_r <= rx_pending_count_r + 2'h1;
    end else if (q_release && !q_store) begin
      rx_pending_count_r <= rx_pending_count_r - 2'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_overrun_r <= 1'b0;
    end else if (i_rx_store && q_full && !q_release) begin
      rx_overrun_r <= 1'b1;
    end else if (rxq_wr && wdat[`CANSR_B_OVERRUN]) begin
      rx_overrun_r <= 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rx_full_r <= 1'b0;
    end else if (q_store && !q_release && rx_pending_count_r == 2'h2) begin
      rx_full_r <= 1'b1;
    end else if (q_release || (rxq_wr && wdat[`CANSR_B_FULL])) begin
      rx_full_r <= 1'b0;
    end
  end

  // enables
  logic [7:0] int_en_r;
  logic [7:0] err_en_r;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      int_en_r <= `CANSR_RST_ZERO;
    end else if (wr_hit(`CANSR_OFF_INT_EN)) begin
      int_en_r <= wdat & `CANSR_INT_EN_MASK;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      err_en_r <= `CANSR_RST_ZERO;
    end else if (wr_hit(`CANSR_OFF_ERR_INT_EN)) begin
      err_en_r <= wdat & `CANSR_ERR_EN_MASK;
    end
  end

  // error status
  cansr_lec_t last_error_code_r;
  logic       bus_off_flag_r;
  logic       error_passive_flag_r;
  logic       error_warning_flag_r;
  logic       error_summary_flag_r;
  logic       hw_lec;

  // code 7 is never produced by hardware, so software can spot updates
  assign hw_lec = i_error_detect && (i_error_code != `CANSR_LEC_SW_ONLY);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      last_error_code_r <= CANSR_LEC_NONE;
    end else if (hw_lec) begin
      last_error_code_r <= cansr_lec_t'(i_error_code);
    end else if (i_frame_ok) begin
      last_error_code_r <= CANSR_LEC_NONE;
    end else if (wr_hit(`CANSR_OFF_ERR_STATUS)) begin
      last_error_code_r <= cansr_lec_t'(wdat[`CANSR_B_LEC_LO +: 3]);
    end
  end

  logic bus_off_flag_nxt;
  logic epv_nxt;
  logic ewg_nxt;
  assign bus_off_flag_nxt = i_tx_err_count[8];
  assign epv_nxt  = (i_tx_err_count > `CANSR_LIMIT_PASSIVE) ||
                    ({1'b0, i_rx_err_count} > `CANSR_LIMIT_PASSIVE);
  assign ewg_nxt  = (i_tx_err_count > `CANSR_LIMIT_WARN) ||
                    ({1'b0, i_rx_err_count} > `CANSR_LIMIT_WARN);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      bus_off_flag_r       <= 1'b0;
      error_passive_flag_r <= 1'b0;
      error_warning_flag_r <= 1'b0;
    end else begin
      bus_off_flag_r       <= bus_off_flag_nxt;
      error_passive_flag_r <= epv_nxt;
      error_warning_flag_r <= ewg_nxt;
    end
  end

  logic err_event;
  assign err_event = (hw_lec && err_en_r[`CANSR_B_LAST_ERROR_INT_EN]) ||
                     (bus_off_flag_nxt && !bus_off_flag_r && err_en_r[`CANSR_B_BUS_OFF_FLAG]) ||
                     (epv_nxt && !error_passive_flag_r && err_en_r[`CANSR_B_EPV]) ||
                     (ewg_nxt && !error_warning_flag_r && err_en_r[`CANSR_B_EWG]);

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      error_summary_flag_r <= 1'b0;
    end else if (err_event) begin
      error_summary_flag_r <= 1'b1;
    end else if (wr_hit(`CANSR_OFF_MASTER_STAT) && wdat[`CANSR_B_ERR_SUM]) begin
      error_summary_flag_r <= 1'b0;
    end
  end

  // interrupt requests
  logic fmp_rise_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      fmp_rise_r <= 1'b0;
    end else begin
      fmp_rise_r <= (rx_pending_count_r == 2'h0) && q_store && !q_release;
    end
  end

  logic [1:0] rqcp_prev_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      rqcp_prev_r <= 2'h0;
    end else begin
      rqcp_prev_r <= request_done_r;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_tx_irq     <= 1'b0;
      o_rx_irq     <= 1'b0;
      o_status_irq <= 1'b0;
    end else begin
      o_tx_irq     <= int_en_r[`CANSR_B_MAILBOX_EMPTY_INT_EN] && |(request_done_r & ~rqcp_prev_r);
      o_rx_irq     <= (int_en_r[`CANSR_B_PENDING_INT_EN] && fmp_rise_r) ||
                      (int_en_r[`CANSR_B_QUEUE_FULL_INT_EN] && rx_full_r) ||
                      (int_en_r[`CANSR_B_OVERRUN_INT_EN] && rx_overrun_r);
      o_status_irq <= (int_en_r[`CANSR_B_WAKEUP_INT_EN] && wakeup_flag_r) ||
                      (err_en_r[`CANSR_B_ERROR_INT_EN] && error_summary_flag_r);
    end
  end

  // read mux, captured during the wait cycle
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = 8'h00;
    unique case (i_avs_address)
      `CANSR_OFF_MASTER_CTRL: rd_byte = ctrl_r;
      `CANSR_OFF_MASTER_STAT: rd_byte = {4'h0, wakeup_flag_r, error_summary_flag_r,
                                         sleep_ack, init_ack};
      `CANSR_OFF_TX_STATUS:   rd_byte = {2'h0, tx_success_r, 2'h0, request_done_r};
      `CANSR_OFF_TX_PRIO:     rd_byte = {1'b0, mbox1_lowest_prio, mbox0_lowest_prio, 1'b0,
                                         mbox_empty, mbox_code};
      `CANSR_OFF_RX_QUEUE:    rd_byte = {2'h0, rx_release_output_r, rx_overrun_r, rx_full_r,
                                         1'b0, rx_pending_count_r};
      `CANSR_OFF_INT_EN:      rd_byte = int_en_r;
      `CANSR_OFF_ERR_STATUS:  rd_byte = {1'b0, last_error_code_r, 1'b0, bus_off_flag_r,
                                         error_passive_flag_r, error_warning_flag_r};
      `CANSR_OFF_ERR_INT_EN:  rd_byte = err_en_r;
      default:                rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read && !done_r) begin
      o_avs_readdata <= {24'h00_0000, rd_byte};
    end
  end

endmodule

//--- tb/cansr_bus_node.sv
// far-side node model: bit ticks and the level seen on the shared can line
// assumes the bench raises i_dom when another node sends a dominant bit
`timescale 1ns/1ps
module cansr_bus_node (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_dom,
  output logic      o_rx,
  output logic      o_tick
);
  logic [2:0] div_r;

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      div_r <= 3'h0;
    end else begin
      div_r <= div_r + 3'h1;
    end
  end

  // one bit time every eight clocks, longer than the rx synchroniser
  assign o_tick = (div_r == 3'h7);
  // wired-and bus idles recessive
  assign o_rx = ~i_dom;
endmodule

//--- tb/cansr_status_asserts.sv
// concurrent checks on the ports of the can status block
// assumes one clock domain and the synchronous active-low reset
`timescale 1ns/1ps
module cansr_status_asserts (
  input wire logic        i_mclk,
  input wire logic        i_rst_n,
  input wire logic [3:0]  i_avs_address,
  input wire logic        i_avs_read,
  input wire logic        i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic        o_avs_waitrequest,
  input wire logic        i_bit_tick,
  input wire logic        i_bus_idle,
  input wire logic [1:0]  i_tx_done,
  input wire logic        o_init_mode,
  input wire logic        o_sleep_mode,
  input wire logic        o_rx_release,
  input wire logic        o_tx_irq
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);

  logic rel_wr_r;

  always_ff @(posedge i_mclk) begin
    rel_wr_r <= i_avs_write && !o_avs_waitrequest && i_avs_address == 4'h4
                && i_avs_writedata[5];
  end

  property p_one_wait;
    $rose(i_avs_read | i_avs_write) |-> o_avs_waitrequest ##1 !o_avs_waitrequest;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("wait state count wrong");
  property p_idle_nowait;
    !(i_avs_read || i_avs_write) |-> !o_avs_waitrequest;
  endproperty
  a_idle_nowait: assert property (p_idle_nowait) else $error("waitrequest while idle");
  property p_modes_apart;
    !(o_init_mode && o_sleep_mode);
  endproperty
  a_modes_apart: assert property (p_modes_apart) else $error("init and sleep");
  property p_sleep_idle;
    $rose(o_sleep_mode) |-> $past(i_bus_idle);
  endproperty
  a_sleep_idle: assert property (p_sleep_idle) else $error("sleep mid frame");
  property p_init_idle;
    $rose(o_init_mode) |-> $past(i_bus_idle);
  endproperty
  a_init_idle: assert property (p_init_idle) else $error("init mid frame");
  property p_sync_tick;
    $fell(o_init_mode) && !o_sleep_mode |->
      $past(i_bit_tick) || $past(i_bit_tick, 2) || $past(i_bit_tick, 3);
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("sync end off a bit");
  property p_rel_cause;
    o_rx_release |-> rel_wr_r || $past(rel_wr_r);
  endproperty
  a_rel_cause: assert property (p_rel_cause) else $error("release without write");
  property p_rel_pulse;
    o_rx_release |=> !o_rx_release;
  endproperty
  a_rel_pulse: assert property (p_rel_pulse) else $error("release too long");
  property p_txirq_cause;
    o_tx_irq |-> $past(i_tx_done, 2) != 2'b00;
  endproperty
  a_txirq_cause: assert property (p_txirq_cause) else $error("tx irq no done");
  property p_txirq_pulse;
    o_tx_irq |=> !o_tx_irq;
  endproperty
  a_txirq_pulse: assert property (p_txirq_pulse) else $error("tx irq too long");
endmodule

bind cansr_status cansr_status_asserts u_chk (.*);

//--- tb/tb_can_status_interrupt_regs.sv
// self-checking bench for the can status block
// assumes one clock and a far-side node model for rx level and bit ticks
`timescale 1ns/1ps
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
`define PUL(s, v) begin @(posedge i_mclk); s <= v; @(posedge i_mclk); s <= '0; end
module tb_can_status_interrupt_regs;
  logic        i_mclk = 1'b0, i_rst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
  logic        i_bus_idle = 1'b1, i_sof_detect = 1'b0, i_mbox0_first = 1'b0, dom = 1'b0;
  logic        i_rx_store = 1'b0, i_error_detect = 1'b0, i_frame_ok = 1'b0;
  logic        o_avs_waitrequest, i_can_rx, i_bit_tick, o_init_mode, o_sleep_mode;
  logic        o_rx_release, o_tx_irq, o_rx_irq, o_status_irq;
  logic [1:0]  i_tx_request = 2'h0, i_tx_done = 2'h0, i_tx_ok = 2'h1;
  logic [2:0]  i_error_code = 3'h0;
  logic [3:0]  i_avs_address = 4'h0, i_avs_byteenable = 4'h1;
  logic [7:0]  i_rx_err_count = 8'h00, rd_v;
  logic [8:0]  i_tx_err_count = 9'h000;
  logic [31:0] i_avs_writedata = 32'h0000_0000, o_avs_readdata;
  int          err_count = 0, compares = 0;

  cansr_status DUT (.*);
  cansr_bus_node u_node (.i_mclk, .i_rst_n, .i_dom(dom), .o_rx(i_can_rx), .o_tick(i_bit_tick));

  always #4 i_mclk = ~i_mclk;

  task automatic tick(input int n);
    repeat (n) @(negedge i_mclk);
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    i_avs_read <= !w;
    i_avs_write <= w;
    i_avs_address <= a;
    i_avs_writedata <= {24'h00_0000, d};
    // sampled at the rising edge itself, before that edge's updates land
    do begin
      @(posedge i_mclk);
      n++;
    end while (o_avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) err_count++;
    rd_v = o_avs_readdata[7:0];
    i_avs_read <= 1'b0;
    i_avs_write <= 1'b0;
  endtask

  task automatic chk_reg(input logic [3:0] a, input logic [7:0] e, input string n);
    bus(1'b0, a, 8'h00);
    `CHK(n, e, rd_v)
  endtask

  task automatic t_reset();
    logic [7:0] ex_t [8] = '{8'h02, 8'h02, 8'h00, 8'h0c, 8'h00, 8'h00, 8'h00, 8'h00};
    for (int i = 0; i < 8; i++) chk_reg(i[3:0], ex_t[i], "reset value");
    chk_reg(4'h9, 8'h00, "unmapped");
    i_avs_byteenable <= 4'h0;
    bus(1'b1, 4'h5, 8'h8f);
    i_avs_byteenable <= 4'h1;
    chk_reg(4'h5, 8'h00, "lane off");
    $display("test reset done");
  endtask

  task automatic t_modes();
    bus(1'b1, 4'h5, 8'h80);
    `PUL(i_sof_detect, 1'b1)
    tick(2);
    `CHK("wakeup irq", 1'b1, o_status_irq)
    chk_reg(4'h1, 8'h0a, "wakeup flag");
    bus(1'b1, 4'h1, 8'h08);
    chk_reg(4'h1, 8'h02, "wakeup clear");
    `CHK("wakeup irq off", 1'b0, o_status_irq)
    bus(1'b1, 4'h0, 8'h00);
    tick(2);
    `CHK("sleep ack", 1'b0, o_sleep_mode)
    bus(1'b1, 4'h0, 8'h01);
    tick(2);
    `CHK("init ack", 1'b1, o_init_mode)
    dom <= 1'b1;
    bus(1'b1, 4'h0, 8'h00);
    @(posedge i_mclk iff i_bit_tick);
    dom <= 1'b0;
    repeat (10) @(posedge i_mclk iff i_bit_tick);
    tick(3);
    `CHK("sync ten", 1'b1, o_init_mode)
    @(posedge i_mclk iff i_bit_tick);
    tick(3);
    `CHK("sync eleven", 1'b0, o_init_mode)
    $display("test modes done");
  endtask

  task automatic t_tx();
    bus(1'b1, 4'h5, 8'h01);
    `PUL(i_tx_request, 2'b11)
    chk_reg(4'h3, 8'h20, "prio both");
    `PUL(i_tx_done, 2'b01)
    tick(2);
    `CHK("tx irq", 1'b1, o_tx_irq)
    chk_reg(4'h2, 8'h11, "done ok0");
    chk_reg(4'h3, 8'h04, "prio one");
    bus(1'b1, 4'h2, 8'h00);
    chk_reg(4'h2, 8'h11, "write zero");
    `PUL(i_tx_request, 2'b01)
    chk_reg(4'h2, 8'h00, "re-request");
    i_mbox0_first <= 1'b1;
    chk_reg(4'h3, 8'h41, "prio swap");
    i_mbox0_first <= 1'b0;
    `PUL(i_tx_done, 2'b10)
    chk_reg(4'h2, 8'h02, "done fail1");
    chk_reg(4'h3, 8'h09, "prio code");
    bus(1'b1, 4'h2, 8'h02);
    chk_reg(4'h2, 8'h00, "clear done1");
    $display("test transmit done");
  endtask

  task automatic t_rx();
    bus(1'b1, 4'h5, 8'h0e);
    `PUL(i_rx_store, 1'b1)
    tick(2);
    `CHK("pending irq", 1'b1, o_rx_irq)
    tick(1);
    `CHK("pending irq end", 1'b0, o_rx_irq)
    `PUL(i_rx_store, 1'b1)
    `PUL(i_rx_store, 1'b1)
    tick(2);
    `CHK("full irq", 1'b1, o_rx_irq)
    chk_reg(4'h4, 8'h0b, "full");
    `PUL(i_rx_store, 1'b1)
    chk_reg(4'h4, 8'h1b, "overrun");
    bus(1'b1, 4'h4, 8'h10);
    chk_reg(4'h4, 8'h0b, "overrun clear");
    bus(1'b1, 4'h4, 8'h20);
    tick(1);
    `CHK("release pulse", 1'b1, o_rx_release)
    tick(2);
    chk_reg(4'h4, 8'h02, "release");
    `PUL(i_rx_store, 1'b1)
    bus(1'b1, 4'h4, 8'h08);
    chk_reg(4'h4, 8'h03, "full clear");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, 4'h4, 8'h20);
      tick(3);
    end
    chk_reg(4'h4, 8'h00, "empty");
    `CHK("rx irq idle", 1'b0, o_rx_irq)
    $display("test receive done");
  endtask

  task automatic t_err();
    logic [8:0] tx_t [6] = '{9'h060, 9'h061, 9'h07f, 9'h080, 9'h100, 9'h000};
    logic [7:0] rx_t [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80};
    logic [7:0] ex_t [6] = '{8'h00, 8'h01, 8'h01, 8'h03, 8'h07, 8'h03};
    bus(1'b1, 4'h7, 8'h97);
    for (int i = 0; i < 6; i++) begin
      i_tx_err_count <= tx_t[i];
      i_rx_err_count <= rx_t[i];
      chk_reg(4'h6, ex_t[i], "error flags");
    end
    tick(1);
    `CHK("error irq", 1'b1, o_status_irq)
    chk_reg(4'h1, 8'h04, "summary");
    bus(1'b1, 4'h7, 8'h17);
    tick(2);
    `CHK("error irq off", 1'b0, o_status_irq)
    for (int c = 1; c < 7; c++) begin
      i_error_code <= c[2:0];
      `PUL(i_error_detect, 1'b1)
      chk_reg(4'h6, {1'b0, c[2:0], 4'h3}, "last error");
    end
    bus(1'b1, 4'h1, 8'h04);
    `PUL(i_error_detect, 1'b1)
    chk_reg(4'h1, 8'h04, "code summary");
    bus(1'b1, 4'h7, 8'h07);
    bus(1'b1, 4'h1, 8'h04);
    `PUL(i_error_detect, 1'b1)
    chk_reg(4'h1, 8'h00, "code masked");
    `PUL(i_frame_ok, 1'b1)
    chk_reg(4'h6, 8'h03, "frame ok");
    i_error_code <= 3'h7;
    `PUL(i_error_detect, 1'b1)
    chk_reg(4'h6, 8'h03, "hw code seven");
    bus(1'b1, 4'h6, 8'h70);
    chk_reg(4'h6, 8'h73, "software code");
    $display("test errors done");
  endtask

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // whole run is a few hundred cycles
  initial begin
    #100000;
    err_count++;
    finish_test();
  end

  initial begin
    repeat (4) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset();
    t_modes();
    t_tx();
    t_rx();
    t_err();
    finish_test();
  end
endmodule
